/* File: src/lpm_pkg.sv */
// constants and types shared by the link power mode block
package lpm_pkg;

    // received and transmitted primitive codes on the dword ports
    localparam int         PRIM_W       = 4;
    localparam logic [3:0] PRIM_NONE    = 4'h0;
    localparam logic [3:0] PRIM_ALIGN   = 4'h1;
    localparam logic [3:0] PRIM_SYNC    = 4'h2;
    localparam logic [3:0] PRIM_X_RDY   = 4'h3;
    localparam logic [3:0] PRIM_R_OK    = 4'h4;
    localparam logic [3:0] PRIM_PMACK   = 4'h5;
    localparam logic [3:0] PRIM_PMNAK   = 4'h6;
    localparam logic [3:0] PRIM_PMREQ_P = 4'h7;
    localparam logic [3:0] PRIM_PMREQ_S = 4'h8;
    localparam logic [3:0] PRIM_DATA    = 4'h9;

    // register byte offsets
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_STATUS   = 4'h4;
    localparam logic [3:0] REG_EVENT    = 4'h8;

    // control register fields and reset values
    localparam int         CTRL_ALLOW_BIT = 0;
    localparam int         CTRL_DRIVE_BIT = 1;
    localparam int         CTRL_N_LSB     = 8;
    localparam int         ACK_N_W        = 5;
    localparam logic       CTRL_ALLOW_RST = 1'b1;
    localparam logic       CTRL_DRIVE_RST = 1'b1;
    localparam logic [4:0] ACK_N_RST      = 5'h04;
    localparam logic [4:0] ACK_N_MIN      = 5'h04;
    localparam logic [4:0] ACK_N_MAX      = 5'h10;

    // status register fields
    localparam int         STAT_STATE_LSB = 0;
    localparam int         STAT_PART_BIT  = 8;
    localparam int         STAT_SLUM_BIT  = 9;
    localparam int         STAT_RDY_BIT   = 10;
    localparam int         STAT_FLAG_BIT  = 11;

    // event register bits, write one to clear
    localparam int         EVT_ERR_BIT    = 0;
    localparam int         EVT_ABORT_BIT  = 1;
    localparam int         EVT_DENY_BIT   = 2;
    localparam int         EVT_W          = 3;

    typedef enum logic [3:0] {
        idle_state,
        partial_request_state,
        slumber_request_state,
        power_ack_state,
        power_deny_state,
        phy_ready_check_state,
        low_power_wait_state,
        wakeup_first_state,
        wakeup_second_state,
        nak_drain_state,
        no_comm_error_state,
        receive_fifo_wait_state
    } lpm_state_t;

endpackage

/* File: src/lpm_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none
module lpm_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

/* File: src/lpm_fsm.sv */
// link power mode state machine with wishbone control registers
//
// How it works
// - partial request sends PMREQ_P, PMACK to check
// - slumber request sends PMREQ_S, PMACK to check
// - X_RDY abandons request, enters receive path
// - SYNC or R_OK keeps request state
// - host: unexpected dword aborts to idle
// - drive: received PMREQ keeps request state
// - drive: other unexpected dword aborts to idle
// - phy not ready in request: error state
// - PMNAK aborts request, drain naks
// - allowed peer request enters ack, sends PMACK
// - send n PMACK, n 4..16, then check
// - flag records partial or slumber type
// - deny sends PMNAK, stays, idles, or errors
// - disabled power modes: peer request denied
// - check asserts chosen mode until phy drops
// - low power holds mode, waits wake cause
// - first wakeup negates modes, waits ready
// - second wakeup sends ALIGN, idle or error
// - nak drain sends SYNC while PMNAK arrives
`timescale 1ns/1ns
`default_nettype none
module lpm_fsm
    import lpm_pkg::*;
(
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST,
    // wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [3:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // transport layer
    input  wire logic        TL_PARTIAL_REQ,
    input  wire logic        TL_SLUMBER_REQ,
    input  wire logic        TL_WAKE_REQ,
    output logic             TL_ERROR,
    output logic             TL_ABORT,
    output logic             TL_DENY,
    // dword stream
    input  wire logic        RX_VALID,
    input  wire logic [3:0]  RX_PRIM,
    output logic      [3:0]  TX_PRIM,
    // physical layer
    input  wire logic        PHY_READY,
    input  wire logic        COMWAKE_DET,
    output logic             PHY_PARTIAL,
    output logic             PHY_SLUMBER,
    // hand-off to the rest of the link
    output logic             RCV_HANDOFF,
    output logic             LINK_ERR_STATE,
    input  wire logic        LINK_RESUME
);

    lpm_state_t       state;
    lpm_state_t       next_state;
    logic             phy_rdy;
    logic             comwake;
    logic             phy_not_ready;
    logic             pm_allow;
    logic             drive_side;
    logic [4:0]       ack_n;
    logic [4:0]       ack_n_eff;
    logic [4:0]       ack_cnt;
    logic             lp_slumber;
    logic             next_lp_slumber;
    logic             err_ev;
    logic             abort_ev;
    logic             deny_ev;
    logic [EVT_W-1:0] events;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;
    logic             wb_req;
    logic             wb_take;
    logic             wr_ctrl;
    logic             wr_event;
    logic             rx_pmreq;
    logic [3:0]       next_tx;
    logic [31:0]      rd_mux;

    // pins from outside the clock domain
    lpm_sync #(
        .W (2)
    ) u_sync (
        .clk (MCLK),
        .rst (RST),
        .d   ({PHY_READY, COMWAKE_DET}),
        .q   ({phy_rdy, comwake})
    );

    assign phy_not_ready = ~phy_rdy;
    assign rx_pmreq      = (RX_PRIM == PRIM_PMREQ_P) ||
                           (RX_PRIM == PRIM_PMREQ_S);

    // ack count clamped so software cannot leave the legal window
    // count window
    assign ack_n_eff = (ack_n < ACK_N_MIN) ? ACK_N_MIN :
                       (ack_n > ACK_N_MAX) ? ACK_N_MAX : ack_n;

    // next state; one dword per visit in the dword-paced states
    always_comb begin
        next_state      = state;
        next_lp_slumber = lp_slumber;
        err_ev          = 1'b0;
        abort_ev        = 1'b0;
        deny_ev         = 1'b0;
        unique case (state)
            idle_state: begin
                if (TL_PARTIAL_REQ) begin
                    next_state = partial_request_state;
                end else if (TL_SLUMBER_REQ) begin
                    next_state = slumber_request_state;
                end else if (RX_VALID && rx_pmreq) begin
                    if (pm_allow) begin
                        next_state      = power_ack_state;
                        next_lp_slumber = (RX_PRIM == PRIM_PMREQ_S);
                    end else begin
                        next_state = power_deny_state;
                        deny_ev    = 1'b1;
                    end
                end
            end
            partial_request_state,
            slumber_request_state: begin
                if (phy_not_ready) begin
                    next_state = no_comm_error_state;
                    err_ev     = 1'b1;
                end else if (RX_VALID) begin
                    unique case (RX_PRIM)
                        PRIM_PMACK: begin
                            next_state      = phy_ready_check_state;
                            next_lp_slumber =
                                (state == slumber_request_state);
                        end
                        PRIM_X_RDY: begin
                            next_state = receive_fifo_wait_state;
                            abort_ev   = 1'b1;
                        end
                        PRIM_SYNC, PRIM_R_OK: begin
                            next_state = state;
                        end
                        PRIM_PMNAK: begin
                            next_state = nak_drain_state;
                            abort_ev   = 1'b1;
                        end
                        PRIM_PMREQ_P, PRIM_PMREQ_S: begin
                            if (drive_side) begin
                                next_state = state;
                            end else begin
                                next_state = idle_state;
                                abort_ev   = 1'b1;
                            end
                        end
                        default: begin
                            next_state = idle_state;
                            abort_ev   = 1'b1;
                        end
                    endcase
                end
            end
            power_ack_state: begin
                if (RX_VALID && (ack_cnt + 5'h01 >= ack_n_eff)) begin
                    next_state = phy_ready_check_state;
                end
            end
            power_deny_state: begin
                if (phy_not_ready) begin
                    next_state = no_comm_error_state;
                    err_ev     = 1'b1;
                end else if (RX_VALID && !rx_pmreq) begin
                    next_state = idle_state;
                end
            end
            phy_ready_check_state: begin
                if (phy_not_ready) begin
                    next_state = low_power_wait_state;
                end
            end
            low_power_wait_state: begin
                if (TL_WAKE_REQ || comwake) begin
                    next_state = wakeup_first_state;
                end
            end
            wakeup_first_state: begin
                if (phy_rdy) begin
                    next_state = wakeup_second_state;
                end
            end
            wakeup_second_state: begin
                if (phy_not_ready) begin
                    next_state = no_comm_error_state;
                    err_ev     = 1'b1;
                end else begin
                    next_state = idle_state;
                end
            end
            nak_drain_state: begin
                if (RX_VALID && (RX_PRIM != PRIM_PMNAK)) begin
                    next_state = idle_state;
                end
            end
            no_comm_error_state,
            receive_fifo_wait_state: begin
                if (LINK_RESUME) begin
                    next_state = idle_state;
                end
            end
        endcase
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state      <= idle_state;
            lp_slumber <= 1'b0;
        end else begin
            state      <= next_state;
            lp_slumber <= next_lp_slumber;
        end
    end

    // PMACK counter, restarted on each entry to the ack state
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ack_cnt <= 5'h00;
        end else if (state != power_ack_state) begin
            ack_cnt <= 5'h00;
        end else if (RX_VALID) begin
            ack_cnt <= ack_cnt + 5'h01;
        end
    end

    // primitive sent in each state
    always_comb begin
        unique case (next_state)
            idle_state:              next_tx = PRIM_SYNC;
            partial_request_state:   next_tx = PRIM_PMREQ_P;
            slumber_request_state:   next_tx = PRIM_PMREQ_S;
            power_ack_state:         next_tx = PRIM_PMACK;
            power_deny_state:        next_tx = PRIM_PMNAK;
            wakeup_second_state:     next_tx = PRIM_ALIGN;
            nak_drain_state:         next_tx = PRIM_SYNC;
            default:                 next_tx = PRIM_NONE;
        endcase
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            TX_PRIM <= PRIM_SYNC;
        end else begin
            TX_PRIM <= next_tx;
        end
    end

    // low power requests from flops; the flag picks exactly one
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            PHY_PARTIAL <= 1'b0;
            PHY_SLUMBER <= 1'b0;
        end else if (next_state == phy_ready_check_state ||
                     next_state == low_power_wait_state) begin
            PHY_PARTIAL <= ~next_lp_slumber;
            PHY_SLUMBER <= next_lp_slumber;
        end else begin
            PHY_PARTIAL <= 1'b0;
            PHY_SLUMBER <= 1'b0;
        end
    end

    // transport status pulses and hand-off levels
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            TL_ERROR       <= 1'b0;
            TL_ABORT       <= 1'b0;
            TL_DENY        <= 1'b0;
            RCV_HANDOFF    <= 1'b0;
            LINK_ERR_STATE <= 1'b0;
        end else begin
            TL_ERROR       <= err_ev;
            TL_ABORT       <= abort_ev;
            TL_DENY        <= deny_ev;
            RCV_HANDOFF    <= (next_state == receive_fifo_wait_state);
            LINK_ERR_STATE <= (next_state == no_comm_error_state);
        end
    end

    // wishbone: ack one cycle after the request, dropped next cycle
    assign wb_req   = WB_CYC_I && WB_STB_I;
    assign wb_take  = wb_req && !WB_ACK_O;
    assign wr_ctrl  = wb_take && WB_WE_I && (WB_ADR_I == REG_CTRL);
    assign wr_event = wb_take && WB_WE_I && (WB_ADR_I == REG_EVENT);

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= wb_take;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            pm_allow   <= CTRL_ALLOW_RST;
            drive_side <= CTRL_DRIVE_RST;
            ack_n      <= ACK_N_RST;
        end else if (wr_ctrl) begin
            if (WB_SEL_I[0]) begin
                pm_allow   <= WB_DAT_I[CTRL_ALLOW_BIT];
                drive_side <= WB_DAT_I[CTRL_DRIVE_BIT];
            end
            if (WB_SEL_I[1]) begin
                ack_n <= WB_DAT_I[CTRL_N_LSB +: ACK_N_W];
            end
        end
    end

    // sticky events; a new event wins over a clear in the same cycle
    assign evt_set = {deny_ev, abort_ev, err_ev};
    assign evt_clr = (wr_event && WB_SEL_I[0]) ?
                     WB_DAT_I[EVT_W-1:0] : {EVT_W{1'b0}};

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            events <= {EVT_W{1'b0}};
        end else begin
            events <= (events & ~evt_clr) | evt_set;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (WB_ADR_I)
            REG_CTRL: begin
                rd_mux[CTRL_ALLOW_BIT]            = pm_allow;
                rd_mux[CTRL_DRIVE_BIT]            = drive_side;
                rd_mux[CTRL_N_LSB +: ACK_N_W]     = ack_n;
            end
            REG_STATUS: begin
                rd_mux[STAT_STATE_LSB +: 4]       = state;
                rd_mux[STAT_PART_BIT]             = PHY_PARTIAL;
                rd_mux[STAT_SLUM_BIT]             = PHY_SLUMBER;
                rd_mux[STAT_RDY_BIT]              = phy_rdy;
                rd_mux[STAT_FLAG_BIT]             = lp_slumber;
            end
            REG_EVENT: begin
                rd_mux[EVT_W-1:0]                 = events;
            end
            // unmapped offsets read zero, writes are dropped
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            WB_DAT_O <= 32'h0000_0000;
        end else if (wb_take && !WB_WE_I) begin
            WB_DAT_O <= rd_mux;
        end
    end

endmodule
`default_nettype wire

/* File: testbench/lpm_sva.sv */
// assertions on the ports of the link power mode block
`timescale 1ns/1ns
`default_nettype none
module lpm_sva
    import lpm_pkg::*;
(
    // clock and reset
    input wire logic       MCLK,
    input wire logic       RST,
    // transport layer
    input wire logic       TL_WAKE_REQ,
    input wire logic       TL_ERROR,
    input wire logic       TL_ABORT,
    input wire logic       TL_DENY,
    // dword stream
    input wire logic       RX_VALID,
    input wire logic [3:0] RX_PRIM,
    input wire logic [3:0] TX_PRIM,
    // physical layer and hand-off
    input wire logic       PHY_READY,
    input wire logic       PHY_PARTIAL,
    input wire logic       PHY_SLUMBER,
    input wire logic       RCV_HANDOFF
);
    logic [4:0] acks;
    logic       flag;
    logic       in_req;
    logic       ack_tick;
    logic       lp;
    assign in_req   = TX_PRIM == PRIM_PMREQ_P || TX_PRIM == PRIM_PMREQ_S;
    assign ack_tick = TX_PRIM == PRIM_PMACK && RX_VALID;
    assign lp       = PHY_PARTIAL || PHY_SLUMBER;
    // acks seen in the ack state; the entry dword is not counted
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST || TX_PRIM != PRIM_PMACK)
            acks <= 5'h00;
        else if (RX_VALID)
            acks <= acks + 5'h01;
    end
    // kind of the last peer request taken outside the ack state
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST)
            flag <= 1'b0;
        else if (RX_VALID && !ack_tick && RX_PRIM inside {7, 8})
            flag <= RX_PRIM == PRIM_PMREQ_S;
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    // synced ready is high once the pin was high three edges running
    sequence s_rdy; PHY_READY [*3]; endsequence
    sequence s_got(logic [3:0] p); in_req && RX_VALID && RX_PRIM == p; endsequence
    property p_excl; !(PHY_PARTIAL && PHY_SLUMBER); endproperty
    property p_ack_min; ack_tick && acks < 5'h03 |=> !lp; endproperty
    property p_ack_max; ack_tick && acks == 5'h0f |=> lp; endproperty
    property p_err; in_req && $fell(PHY_READY) |-> ##[1:4] TL_ERROR; endproperty
    property p_wake;
        (lp && !PHY_READY) [*4] ##0 TL_WAKE_REQ |=> !lp;
    endproperty
    property p_align;
        $rose(TX_PRIM == PRIM_ALIGN) |-> !lp ##1 TX_PRIM != PRIM_ALIGN;
    endproperty
    property p_flag;
        $rose(lp) && $past(TX_PRIM) == PRIM_PMACK |-> PHY_SLUMBER == flag;
    endproperty
    property p_deny; TL_DENY |-> TX_PRIM == PRIM_PMNAK; endproperty
    property p_abort; TL_ABORT |-> $past(in_req); endproperty
    property p_xrdy;
        s_rdy ##0 s_got(PRIM_X_RDY) |=> RCV_HANDOFF && TL_ABORT;
    endproperty
    property p_nak;
        s_rdy ##0 s_got(PRIM_PMNAK) |=> TX_PRIM == PRIM_SYNC && TL_ABORT;
    endproperty
    a_excl: assert property (p_excl)
        else $error("partial and slumber both high");
    a_ack_min: assert property (p_ack_min)
        else $error("ack state left before four acks");
    a_ack_max: assert property (p_ack_max)
        else $error("ack state kept past sixteen acks");
    a_err: assert property (p_err)
        else $error("no error after ready loss in request");
    a_wake: assert property (p_wake)
        else $error("wake request did not drop the mode");
    a_align: assert property (p_align)
        else $error("align not a single clock with modes low");
    a_flag: assert property (p_flag)
        else $error("mode does not match the peer request");
    a_deny: assert property (p_deny)
        else $error("deny pulse without nak on the link");
    a_abort: assert property (p_abort)
        else $error("abort pulse outside a request");
    a_xrdy: assert property (p_xrdy)
        else $error("x_rdy did not hand off to receive");
    a_nak: assert property (p_nak)
        else $error("nak did not abort into the drain");
endmodule
bind lpm_fsm lpm_sva lpm_sva_i (.MCLK(MCLK), .RST(RST),
    .TL_WAKE_REQ(TL_WAKE_REQ), .TL_ERROR(TL_ERROR), .TL_ABORT(TL_ABORT),
    .TL_DENY(TL_DENY), .RX_VALID(RX_VALID), .RX_PRIM(RX_PRIM),
    .TX_PRIM(TX_PRIM), .PHY_READY(PHY_READY), .PHY_PARTIAL(PHY_PARTIAL),
    .PHY_SLUMBER(PHY_SLUMBER), .RCV_HANDOFF(RCV_HANDOFF));
`default_nettype wire

/* File: testbench/lpm_peer.sv */
// peer link layer and phy model across the serial link
`timescale 1ns/1ns
`default_nettype none
module lpm_peer
    import lpm_pkg::*;
(
    // clock
    input wire logic   MCLK,
    // mode requests from the block
    input wire logic   PHY_PARTIAL,
    input wire logic   PHY_SLUMBER,
    // dwords and ready towards the block
    output logic       RX_VALID,
    output logic [3:0] RX_PRIM,
    output logic       PHY_READY
);
    logic       fail;
    logic       asleep;
    logic [1:0] cnt;
    initial begin
        fail = 1'b0;
        asleep = 1'b0;
        cnt = 2'h0;
        RX_VALID = 1'b0;
        RX_PRIM = PRIM_NONE;
    end
    // one dword per call; the idle lane shows junk, not the last
    task automatic send(input logic [3:0] p);
        @(posedge MCLK);
        RX_VALID <= 1'b1;
        RX_PRIM  <= p;
        @(posedge MCLK);
        RX_VALID <= 1'b0;
        RX_PRIM  <= ~p;
        #1;
    endtask
    // phy takes four clocks to follow a mode change
    always @(posedge MCLK) begin
        cnt <= (PHY_PARTIAL || PHY_SLUMBER) == asleep ? 2'h0 : cnt + 2'h1;
        if (cnt == 2'h3)
            asleep <= PHY_PARTIAL || PHY_SLUMBER;
    end
    assign PHY_READY = !asleep && !fail;
endmodule
`default_nettype wire

/* File: testbench/test_lpm_fsm.sv */
// self-checking bench for the link power mode block
`timescale 1ns/1ns
`default_nettype none
module test_lpm_fsm
    import lpm_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  tl = 4'h0;
    logic        comwake = 1'b0;
    logic [31:0] rdat, dat_o;
    logic [3:0]  rx_p, tx;
    logic        ack, tl_err, abrt, deny, rx_v, rdy, part, slum, handoff, err_st;
    int          num_errors = 0;
    int          comparisons = 0;
    lpm_fsm lpm_fsm_i (
        .MCLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat),
        .WB_DAT_O(dat_o), .WB_ACK_O(ack), .TL_PARTIAL_REQ(tl[0]),
        .TL_SLUMBER_REQ(tl[1]), .TL_WAKE_REQ(tl[2]), .TL_ERROR(tl_err),
        .TL_ABORT(abrt), .TL_DENY(deny), .RX_VALID(rx_v), .RX_PRIM(rx_p),
        .TX_PRIM(tx), .PHY_READY(rdy), .COMWAKE_DET(comwake),
        .PHY_PARTIAL(part), .PHY_SLUMBER(slum), .RCV_HANDOFF(handoff),
        .LINK_ERR_STATE(err_st), .LINK_RESUME(tl[3]));
    lpm_peer lpm_peer_i (.MCLK(clk), .PHY_PARTIAL(part), .PHY_SLUMBER(slum),
        .RX_VALID(rx_v), .RX_PRIM(rx_p), .PHY_READY(rdy));
    always #25 clk = ~clk;
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task stop_test;
        $display("checks %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one classic cycle; the answer time is left to the slave
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, we, adr, wdat} <= {1'b1, w, a, d};
        do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
        chk("ack", 1'b1, ack);
        rdat = dat_o;
        cyc <= 1'b0;
    endtask
    // one-clock pulse: 0 partial, 1 slumber, 2 wake, 3 resume
    task automatic req(input int k);
        @(posedge clk) tl[k] <= 1'b1;
        @(posedge clk) tl[k] <= 1'b0;
        #1;
    endtask
    task automatic wait_st(input lpm_state_t s);
        int n;
        n = 0;
        do wb(1'b0, REG_STATUS, 32'h0); while (rdat[3:0] !== s && ++n < 30);
        chk("state", s, rdat[3:0]);
    endtask
    task automatic t_regs;
        wb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl", 32'h0000_0403, rdat);
        wb(1'b0, REG_EVENT, 32'h0);
        chk("event", 32'h0, rdat);
        wb(1'b1, 4'hc, 32'hffff_ffff);
        wb(1'b0, 4'hc, 32'h0);
        chk("unmapped", 32'h0, rdat);
    endtask
    task automatic t_partial;
        req(0);
        chk("tx", PRIM_PMREQ_P, tx);
        lpm_peer_i.send(PRIM_R_OK);
        chk("tx", PRIM_PMREQ_P, tx);
        lpm_peer_i.send(PRIM_PMREQ_S);
        chk("tx", PRIM_PMREQ_P, tx);
        lpm_peer_i.send(PRIM_PMACK);
        chk("mode", 2'b01, {slum, part});
        wait_st(low_power_wait_state);
        chk("mode", 2'b01, {slum, part});
        req(2);
        chk("mode", 2'b00, {slum, part});
        wait_st(idle_state);
    endtask
    task automatic t_host;
        wb(1'b1, REG_CTRL, 32'h0000_0401);
        req(1);
        chk("tx", PRIM_PMREQ_S, tx);
        lpm_peer_i.send(PRIM_PMREQ_P);
        chk("abort", 1'b1, abrt);
        wait_st(idle_state);
        wb(1'b1, REG_CTRL, 32'h0000_0403);
        req(0);
        lpm_peer_i.send(PRIM_DATA);
        chk("abort", 1'b1, abrt);
        wait_st(idle_state);
    endtask
    task automatic t_abort;
        req(1);
        lpm_peer_i.send(PRIM_PMNAK);
        chk("tx", PRIM_SYNC, tx);
        chk("abort", 1'b1, abrt);
        lpm_peer_i.send(PRIM_PMNAK);
        wait_st(nak_drain_state);
        lpm_peer_i.send(PRIM_ALIGN);
        wait_st(idle_state);
        req(0);
        lpm_peer_i.send(PRIM_X_RDY);
        chk("handoff", 1'b1, handoff);
        req(3);
        wait_st(idle_state);
    endtask
    // w is the written count, n the count the block should use after clamping
    task automatic t_peer(input logic [4:0] w, input int n,
                          input logic [3:0] p, input logic [1:0] m);
        wb(1'b1, REG_CTRL, {19'h0, w, 8'h03});
        lpm_peer_i.send(p);
        chk("tx", PRIM_PMACK, tx);
        repeat (n - 1) begin
            lpm_peer_i.send(PRIM_SYNC);
            chk("tx", PRIM_PMACK, tx);
        end
        lpm_peer_i.send(PRIM_SYNC);
        chk("mode", m, {slum, part});
        wait_st(low_power_wait_state);
        @(posedge clk) comwake <= 1'b1;
        wait_st(idle_state);
        chk("mode", 2'b00, {slum, part});
        comwake <= 1'b0;
    endtask
    task automatic t_deny;
        wb(1'b1, REG_EVENT, 32'h0000_0007);
        wb(1'b1, REG_CTRL, 32'h0000_0402);
        lpm_peer_i.send(PRIM_PMREQ_P);
        chk("tx", PRIM_PMNAK, tx);
        chk("deny", 1'b1, deny);
        lpm_peer_i.send(PRIM_PMREQ_S);
        chk("tx", PRIM_PMNAK, tx);
        lpm_peer_i.send(PRIM_SYNC);
        wait_st(idle_state);
        lpm_peer_i.send(PRIM_PMREQ_S);
        @(posedge clk) lpm_peer_i.fail <= 1'b1;
        wait_st(no_comm_error_state);
        wb(1'b0, REG_EVENT, 32'h0);
        chk("event", 32'h0000_0005, rdat);
        @(posedge clk) lpm_peer_i.fail <= 1'b0;
        req(3);
        wb(1'b1, REG_CTRL, 32'h0000_0403);
        req(1);
        @(posedge clk) lpm_peer_i.fail <= 1'b1;
        wait_st(no_comm_error_state);
        chk("error state", 1'b1, err_st);
        @(posedge clk) lpm_peer_i.fail <= 1'b0;
        req(3);
        wait_st(idle_state);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        // synced ready needs a few clocks before any request
        repeat (4) @(posedge clk);
        t_regs;
        t_partial;
        t_host;
        t_abort;
        t_peer(5'h03, 4, PRIM_PMREQ_P, 2'b01);
        t_peer(5'h10, 16, PRIM_PMREQ_S, 2'b10);
        t_deny;
        stop_test;
    end
    initial begin
        repeat (10000) @(posedge clk);
        num_errors++;
        stop_test;
    end
endmodule
`default_nettype wire
